// ### cabpc_pkg.sv
package cabpc_pkg;

	// ****************************************
	// Register addresses and layouts
	// ****************************************
	localparam logic [7:0] ADDR_MODE = 8'hd9;
	localparam logic [7:0] ADDR_PWM  = 8'hdf;

	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] PWM_RESET  = 8'h00;

	localparam int MODE_IDLE_BIT    = 7;
	localparam int MODE_WDOG_BIT    = 6;
	localparam int MODE_SRC_LSB     = 1;
	localparam int MODE_CNT_IRQ_BIT = 0;

	localparam int PWM_RELOAD_BIT   = 7;
	localparam int PWM_CYC_IRQ_BIT  = 6;
	localparam int PWM_CYC_FLAG_BIT = 5;
	localparam int PWM_CLS_LSB      = 0;

	// ****************************************
	// Count sources and cycle lengths
	// ****************************************
	typedef enum logic [2:0] {
		SRC_DIV12 = 3'h0,
		SRC_DIV4  = 3'h1,
		SRC_T0OV  = 3'h2,
		SRC_FALL  = 3'h3,
		SRC_SYS   = 3'h4,
		SRC_EXT8  = 3'h5,
		SRC_RSV6  = 3'h6,
		SRC_RSV7  = 3'h7
	} cabpc_src_e;

	typedef enum logic [1:0] {
		CLS_8  = 2'h0,
		CLS_9  = 2'h1,
		CLS_10 = 2'h2,
		CLS_11 = 2'h3
	} cabpc_cls_e;

	localparam logic [3:0]  PRE_MAX_DIV12 = 4'hb;
	localparam logic [3:0]  PRE_MAX_DIV4  = 4'h3;
	localparam logic [2:0]  EXT_DIV_MAX   = 3'h7;
	localparam logic [15:0] CNT_MAX       = 16'hffff;
	localparam int          NUM_CHAN      = 6;

endpackage

// ### cabpc_timebase.sv
`timescale 1ns/1ps
module cabpc_timebase (
	input  wire logic                    core_clk_in,             // System clock.
	input  wire logic                    rst_n_in,                // Async reset, low.
	input  wire logic                    clk_en_in,               // Freezes state when low.
	input  wire logic [7:0]              sfr_addr_in,             // Register address.
	input  wire logic                    sfr_wr_in,               // Write strobe.
	input  wire logic [7:0]              sfr_wdata_in,            // Write data.
	output logic      [7:0]              sfr_rdata_out,           // Read data, one cycle late.
	input  wire logic                    timer0_overflow_in,      // Timer zero overflow pulse.
	input  wire logic                    external_count_input_in, // Falling-edge count pin.
	input  wire logic                    external_clock_in,       // External clock pin.
	input  wire logic                    counter_flag_clear_in,   // Clears overflow flag.
	input  wire logic [5:0]              sixteen_bit_pwm_enable_in, // Per channel mode.
	output logic      [15:0]             main_counter_out,        // Counter value.
	output logic                         counter_overflow_flag_out, // Overflow flag.
	output logic                         reload_register_select_out, // Reload select.
	output logic      [1:0]              cycle_length_select_out, // Cycle length code.
	output logic      [5:0]              channel_cycle_wrap_out,  // Per channel wrap.
	output logic                         irq_out                  // Interrupt request.
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic        idle;
		logic        wdog_en;
		logic [2:0]  src;
		logic        cnt_irq_en;
		logic        reload_sel;
		logic        cyc_irq_en;
		logic        cyc_flag;
		logic [1:0]  cls;
		logic [15:0] cnt;
		logic        cnt_flag;
		logic [3:0]  pre;
		logic [2:0]  ext_div;
		logic        cin_s1;
		logic        cin_s2;
		logic        cin_s3;
		logic        ext_s1;
		logic        ext_s2;
		logic        ext_s3;
		logic [7:0]  rdata;
	} cabpc_state_s;

	cabpc_state_s st_q;
	cabpc_state_s st_d;

	logic        tick;
	logic        cin_fall;
	logic        ext_rise;
	logic        ovf16;
	logic        cyc_hit;
	logic        wr_mode;
	logic        wr_pwm;
	logic [3:0]  pre_max;
	logic [15:0] cyc_mask;

	// Mask of the low counter bits that make up one PWM cycle.
	// Cycle length masks
	function automatic logic [15:0] cls_mask(input logic [1:0] cls);
		logic [15:0] m;
		m = 16'h00ff;
		case (cls)
			cabpc_pkg::CLS_8:  m = 16'h00ff;
			cabpc_pkg::CLS_9:  m = 16'h01ff;
			cabpc_pkg::CLS_10: m = 16'h03ff;
			cabpc_pkg::CLS_11: m = 16'h07ff;
			default:           m = 16'h00ff;
		endcase
		return m;
	endfunction

	// ****************************************
	// Register access decode
	// ****************************************
	assign wr_mode = sfr_wr_in && (sfr_addr_in == cabpc_pkg::ADDR_MODE);
	assign wr_pwm  = sfr_wr_in && (sfr_addr_in == cabpc_pkg::ADDR_PWM);

	// ****************************************
	// Count source selection
	// ****************************************
	// Edge detectors read only the second and third synchroniser stages.
	assign cin_fall = st_q.cin_s3 && !st_q.cin_s2;
	assign ext_rise = st_q.ext_s2 && !st_q.ext_s3;
	assign pre_max  = (st_q.src == cabpc_pkg::SRC_DIV12) ? cabpc_pkg::PRE_MAX_DIV12
	                                                     : cabpc_pkg::PRE_MAX_DIV4;

	always_comb begin
		tick = 1'b0;
		case (cabpc_pkg::cabpc_src_e'(st_q.src))
			cabpc_pkg::SRC_DIV12,
			cabpc_pkg::SRC_DIV4: tick = (st_q.pre == pre_max);
			cabpc_pkg::SRC_SYS:  tick = 1'b1;
			cabpc_pkg::SRC_T0OV: tick = timer0_overflow_in;
			cabpc_pkg::SRC_FALL: tick = cin_fall;
			cabpc_pkg::SRC_EXT8: tick = ext_rise && (st_q.ext_div == cabpc_pkg::EXT_DIV_MAX);
			default:             tick = 1'b0;
		endcase
	end

	// ****************************************
	// Overflow detection
	// ****************************************
	assign cyc_mask = cls_mask(st_q.cls);
	assign ovf16    = tick && (st_q.cnt == cabpc_pkg::CNT_MAX);
	assign cyc_hit  = tick && ((st_q.cnt & cyc_mask) == cyc_mask);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.cin_s1 = external_count_input_in;
		st_d.cin_s2 = st_q.cin_s1;
		st_d.cin_s3 = st_q.cin_s2;
		st_d.ext_s1 = external_clock_in;
		st_d.ext_s2 = st_q.ext_s1;
		st_d.ext_s3 = st_q.ext_s2;

		// The prescaler keeps its count across a switch between SRC_DIV12 and SRC_DIV4, so the first tick may come early.
		if ((st_q.src == cabpc_pkg::SRC_DIV12) || (st_q.src == cabpc_pkg::SRC_DIV4)) begin
			st_d.pre = (st_q.pre >= pre_max) ? 4'h0 : st_q.pre + 4'h1;
		end else begin
			st_d.pre = 4'h0;
		end

		if (ext_rise) begin
			st_d.ext_div = st_q.ext_div + 3'h1;
		end

		if (tick) begin
			st_d.cnt = st_q.cnt + 16'h1;
		end

		// Counter flag: a new overflow wins over a clear in the same cycle.
		if (counter_flag_clear_in) begin
			st_d.cnt_flag = 1'b0;
		end
		if (ovf16) begin
			st_d.cnt_flag = 1'b1;
		end

		if (wr_mode && !st_q.wdog_en) begin
			st_d.idle       = sfr_wdata_in[cabpc_pkg::MODE_IDLE_BIT];
			st_d.wdog_en    = sfr_wdata_in[cabpc_pkg::MODE_WDOG_BIT];
			st_d.src        = sfr_wdata_in[cabpc_pkg::MODE_SRC_LSB +: 3];
			st_d.cnt_irq_en = sfr_wdata_in[cabpc_pkg::MODE_CNT_IRQ_BIT];
		end

		if (wr_pwm) begin
			st_d.reload_sel = sfr_wdata_in[cabpc_pkg::PWM_RELOAD_BIT];
			st_d.cyc_irq_en = sfr_wdata_in[cabpc_pkg::PWM_CYC_IRQ_BIT];
			st_d.cyc_flag   = sfr_wdata_in[cabpc_pkg::PWM_CYC_FLAG_BIT];
			st_d.cls        = sfr_wdata_in[cabpc_pkg::PWM_CLS_LSB +: 2];
		end
		if (cyc_hit) begin
			st_d.cyc_flag = 1'b1;
		end

		// Reserved bits read as zero.
		case (sfr_addr_in)
			cabpc_pkg::ADDR_MODE: st_d.rdata = {st_q.idle, st_q.wdog_en, 2'b00,
			                                    st_q.src, st_q.cnt_irq_en};
			cabpc_pkg::ADDR_PWM:  st_d.rdata = {st_q.reload_sel, st_q.cyc_irq_en, st_q.cyc_flag,
			                                    3'b000, st_q.cls};
			default:              st_d.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q       <= '0;
			st_q.idle       <= cabpc_pkg::MODE_RESET[cabpc_pkg::MODE_IDLE_BIT];
			st_q.wdog_en    <= cabpc_pkg::MODE_RESET[cabpc_pkg::MODE_WDOG_BIT];
			st_q.src        <= cabpc_pkg::MODE_RESET[cabpc_pkg::MODE_SRC_LSB +: 3];
			st_q.cnt_irq_en <= cabpc_pkg::MODE_RESET[cabpc_pkg::MODE_CNT_IRQ_BIT];
			st_q.reload_sel <= cabpc_pkg::PWM_RESET[cabpc_pkg::PWM_RELOAD_BIT];
			st_q.cyc_irq_en <= cabpc_pkg::PWM_RESET[cabpc_pkg::PWM_CYC_IRQ_BIT];
			st_q.cyc_flag   <= cabpc_pkg::PWM_RESET[cabpc_pkg::PWM_CYC_FLAG_BIT];
			st_q.cls        <= cabpc_pkg::PWM_RESET[cabpc_pkg::PWM_CLS_LSB +: 2];
		end else if (clk_en_in) begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sfr_rdata_out             = st_q.rdata;
	assign main_counter_out          = st_q.cnt;
	assign counter_overflow_flag_out = st_q.cnt_flag;
	assign cycle_length_select_out   = st_q.cls;
	assign reload_register_select_out = st_q.reload_sel;

	// Sixteen-bit channels wrap on full count
	always_comb begin
		for (int i = 0; i < cabpc_pkg::NUM_CHAN; i++) begin
			channel_cycle_wrap_out[i] = sixteen_bit_pwm_enable_in[i] ? ovf16 : cyc_hit;
		end
	end

	assign irq_out = (st_q.cnt_flag && st_q.cnt_irq_en) || (st_q.cyc_flag && st_q.cyc_irq_en);

	// ****************************************
	// Checks
	// ****************************************
	property p_div12;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && (st_q.src == cabpc_pkg::SRC_DIV12) && tick
		|-> st_q.pre == cabpc_pkg::PRE_MAX_DIV12;
	endproperty
	a_div12: assert property (p_div12) else $error("div12 tick off count");

	// A tick must return exactly four enabled cycles later while the source stays put.
	property p_div4;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && (st_q.src == cabpc_pkg::SRC_DIV4) && tick
		##1 (clk_en_in && (st_q.src == cabpc_pkg::SRC_DIV4)) [*3]
		|=> (st_q.src != cabpc_pkg::SRC_DIV4) || tick;
	endproperty
	a_div4: assert property (p_div4) else $error("div4 tick spacing wrong");

	property p_sys;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && (st_q.src == cabpc_pkg::SRC_SYS) && !wr_mode
		|=> st_q.cnt == $past(st_q.cnt) + 16'h1;
	endproperty
	a_sys: assert property (p_sys) else $error("counter missed system clock");

	property p_t0;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && (st_q.src == cabpc_pkg::SRC_T0OV) && timer0_overflow_in
		|=> st_q.cnt == $past(st_q.cnt) + 16'h1;
	endproperty
	a_t0: assert property (p_t0) else $error("timer zero overflow not counted");

	property p_rsv;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && (st_q.src[2:1] == 2'b11) && !wr_mode |=> $stable(st_q.cnt);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved source counted");

	property p_fall;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(st_q.src == cabpc_pkg::SRC_FALL) && tick |-> st_q.cin_s3 && !st_q.cin_s2;
	endproperty
	a_fall: assert property (p_fall) else $error("count without falling edge");

	property p_ext8;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(st_q.src == cabpc_pkg::SRC_EXT8) && tick
		|-> ext_rise && st_q.ext_div == cabpc_pkg::EXT_DIV_MAX;
	endproperty
	a_ext8: assert property (p_ext8) else $error("external divide wrong");

	property p_cnt_irq;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!st_q.cnt_irq_en && !(st_q.cyc_flag && st_q.cyc_irq_en) |-> !irq_out;
	endproperty
	a_cnt_irq: assert property (p_cnt_irq) else $error("request while masked");

	property p_cov_irq;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && cyc_hit && st_q.cyc_irq_en && !wr_pwm |=> irq_out;
	endproperty
	a_cov_irq: assert property (p_cov_irq) else $error("cycle overflow no irq");

	property p_cyc_flag_set;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && tick && ((st_q.cnt & cls_mask(st_q.cls)) == cls_mask(st_q.cls))
		|=> st_q.cyc_flag;
	endproperty
	a_cyc_flag_set: assert property (p_cyc_flag_set) else $error("cycle flag not set");

	property p_cyc_flag_hold;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		st_q.cyc_flag && !(clk_en_in && wr_pwm) |=> st_q.cyc_flag;
	endproperty
	a_cyc_flag_hold: assert property (p_cyc_flag_hold) else $error("cycle flag lost");

	property p_lock;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		st_q.wdog_en && wr_mode
		|=> $stable(st_q.src) && $stable(st_q.cnt_irq_en) && st_q.wdog_en;
	endproperty
	a_lock: assert property (p_lock) else $error("mode write while locked");

	property p_wrap16;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		sixteen_bit_pwm_enable_in[0] && channel_cycle_wrap_out[0]
		|-> main_counter_out == cabpc_pkg::CNT_MAX;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("sixteen bit wrap early");

endmodule

// ### tb_counter_array_timebase_pwm_config.sv
`timescale 1ns/1ps
module tb_counter_array_timebase_pwm_config;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic        clk_en  = 1'b1;
	logic [7:0]  addr    = 8'h00;
	logic        wr_s    = 1'b0;
	logic [7:0]  wdata   = 8'h00;
	logic [7:0]  rdata;
	logic        t0      = 1'b0;
	logic        cin     = 1'b1;
	logic        ext     = 1'b0;
	logic        flg_clr = 1'b0;
	logic [5:0]  sixteen = 6'h00;
	logic [15:0] cnt;
	logic        cnt_flag;
	logic        rsel;
	logic [1:0]  cls;
	logic [5:0]  wrap;
	logic        irq;
	logic [7:0]  rv;
	int          n_errors;
	int          samples_checked;
	int          cycles;

	cabpc_timebase DUT (.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
		.sfr_addr_in(addr), .sfr_wr_in(wr_s), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
		.timer0_overflow_in(t0), .external_count_input_in(cin), .external_clock_in(ext),
		.counter_flag_clear_in(flg_clr), .sixteen_bit_pwm_enable_in(sixteen),
		.main_counter_out(cnt), .counter_overflow_flag_out(cnt_flag),
		.reload_register_select_out(rsel), .cycle_length_select_out(cls),
		.channel_cycle_wrap_out(wrap), .irq_out(irq));

	always #50 clk = ~clk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task results;
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clk);
		wr_s = 1'b0;
	endtask

	// Read data is registered, so it is taken one enabled edge after the address.
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask

	task rate(input logic [7:0] mode, input int n, input logic [15:0] exp);
		logic [15:0] c0;
		wr(cabpc_pkg::ADDR_MODE, mode);
		cyc(4);
		c0 = cnt;
		cyc(n);
		check(cnt - c0, exp);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		rd(cabpc_pkg::ADDR_MODE, rv);
		check(rv, cabpc_pkg::MODE_RESET);
		rd(cabpc_pkg::ADDR_PWM, rv);
		check(rv, cabpc_pkg::PWM_RESET);
		rd(8'h55, rv);
		check(rv, 8'h00);
		wr(cabpc_pkg::ADDR_PWM, 8'hff);
		rd(cabpc_pkg::ADDR_PWM, rv);
		check(rv, 8'he3);
		check(irq, 1'b1);
		check(rsel, 1'b1);
		check(cls, 2'h3);
		wr(cabpc_pkg::ADDR_PWM, 8'hc3);
		rd(cabpc_pkg::ADDR_PWM, rv);
		check(rv, 8'hc3);
		check(irq, 1'b0);
		wr(cabpc_pkg::ADDR_MODE, 8'hbf);
		rd(cabpc_pkg::ADDR_MODE, rv);
		check(rv, 8'h8f);
		wr(cabpc_pkg::ADDR_PWM, 8'h00);
		$display("test registers done");
	endtask

	task t_sources;
		logic [15:0] c0;
		rate(8'h00, 120, 16'd10);
		rate(8'h02, 120, 16'd30);
		rate(8'h08, 120, 16'd120);
		rate(8'h0c, 60, 16'd0);
		rate(8'h0e, 60, 16'd0);
		wr(cabpc_pkg::ADDR_MODE, 8'h04);
		c0 = cnt;
		repeat (5) begin
			t0 = 1'b1;
			cyc(1);
			t0 = 1'b0;
			cyc(3);
		end
		check(cnt - c0, 16'd5);
		wr(cabpc_pkg::ADDR_MODE, 8'h06);
		cyc(4);
		c0 = cnt;
		// Input rate limit
		// Each level is held four cycles to respect the maximum input rate.
		repeat (4) begin
			cin = 1'b0;
			cyc(4);
			cin = 1'b1;
			cyc(4);
		end
		cyc(4);
		check(cnt - c0, 16'd4);
		wr(cabpc_pkg::ADDR_MODE, 8'h0a);
		cyc(4);
		c0 = cnt;
		repeat (16) begin
			ext = 1'b1;
			cyc(3);
			ext = 1'b0;
			cyc(3);
		end
		cyc(6);
		check(cnt - c0, 16'd2);
		wr(cabpc_pkg::ADDR_MODE, 8'h08);
		cyc(2);
		c0 = cnt;
		clk_en = 1'b0;
		cyc(20);
		check(cnt - c0, 16'd0);
		clk_en = 1'b1;
		$display("test sources done");
	endtask

	task t_cycle;
		int k;
		int lim;
		for (int n = 0; n < 4; n++) begin
			lim = 1 << (8 + n);
			wr(cabpc_pkg::ADDR_PWM, 8'h40 | 8'(n));
			k = 0;
			while (irq !== 1'b1 && k < lim + 4) begin
				cyc(1);
				k++;
			end
			check(16'(k <= lim), 16'd1);
			check(cnt & 16'(lim - 1), 16'd0);
			cyc(20);
			check(irq, 1'b1);
			// Writing zero clears the flag and returns the cycle length to eight bits.
			wr(cabpc_pkg::ADDR_PWM, 8'h00);
			rd(cabpc_pkg::ADDR_PWM, rv);
			check(rv, 8'h00);
		end
		sixteen = 6'h01;
		k = 0;
		while (cnt[7:0] !== 8'hff && k < 300) begin
			cyc(1);
			k++;
		end
		check(wrap, 6'h3e);
		sixteen = 6'h00;
		$display("test cycle length done");
	endtask

	task t_cflag;
		int k;
		wr(cabpc_pkg::ADDR_MODE, 8'h09);
		sixteen = 6'h01;
		k = 0;
		while (cnt !== cabpc_pkg::CNT_MAX && k < 66000) begin
			cyc(1);
			k++;
		end
		check(wrap, 6'h3f);
		sixteen = 6'h00;
		cyc(1);
		check(cnt_flag, 1'b1);
		check(irq, 1'b1);
		wr(cabpc_pkg::ADDR_MODE, 8'h08);
		check(irq, 1'b0);
		rd(cabpc_pkg::ADDR_PWM, rv);
		check(rv, 8'h20);
		flg_clr = 1'b1;
		cyc(1);
		flg_clr = 1'b0;
		check(cnt_flag, 1'b0);
		$display("test counter flag done");
	endtask

	// Once locked, only a reset frees the mode register, so this runs last.
	task t_lock;
		wr(cabpc_pkg::ADDR_MODE, 8'h40);
		wr(cabpc_pkg::ADDR_MODE, 8'h09);
		rd(cabpc_pkg::ADDR_MODE, rv);
		check(rv, 8'h40);
		$display("test lock done");
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			results;
		end
	end

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_regs;
		t_sources;
		t_cycle;
		t_cflag;
		t_lock;
		results;
	end
endmodule
